// ---- hw/vhp_pkg.sv ----
/*
  Shared constants for the video host port and stream fix-up block: the sizes
  of the host tables, the write table's reset image, field positions of the control bits,
  the serial address and the timing-reference code words.
  Assumes a single 100 MHz clock domain and a 10-bit video word path.
*/
// Operation
// - Insert timing references at flywheel positions when enabled.
// - Insertion needs detected standard and locked flywheel.
// - Lost input keeps inserting using last standard.
// - Correctly placed references are still overwritten.
// - Combined pin ORs clip, reference-blank and insert bits.
// - Aux header words 3FC to 3FF become 3FF.
// - Fifteen write bytes and twenty-three read bytes.
// - Select pin high means serial, low parallel.
// - Default-0 bits OR pins; default-1 bits AND, except checksum.
// - Serial address is 0001 plus three strap pins.
// - Serial write: first byte address, then auto-increment.
// - Serial read resumes at next address after halt.
// - Parallel cycles independent of the video clock.
// - Parallel transfers strobed on chip select falling edge.
// - Bus driven only when read high, select low.
// - Parallel read: address write, then select presents data.
// - Consecutive parallel data transfers auto-increment address.
package vhp_pkg;

  // Table geometry; locations are numbered from 1.
  localparam int unsigned WTAB_WORDS = 15;
  localparam int unsigned RTAB_WORDS = 23;
  localparam int unsigned TAB_ADDR_W = 5;
  localparam logic [TAB_ADDR_W-1:0] TAB_FIRST = 5'h01;

  // Location of the processing control byte and its fields.
  localparam logic [TAB_ADDR_W-1:0] PROC_ADDR = 5'h03;
  localparam int unsigned BIT_CLIP      = 7;
  localparam int unsigned BIT_BLANK_EN  = 6;
  localparam int unsigned BIT_AUX_REMAP = 5;
  localparam int unsigned BIT_AUX_CHKSM = 2;
  localparam int unsigned BIT_INSERT    = 1;
  localparam int unsigned BIT_REF_BLANK = 0;
  localparam int unsigned VBLANK_SEL_BYTE = 2;
  localparam int unsigned VBLANK_SEL_BIT  = 6;

  // Reset image of the write table, location 1 in the low byte.
  localparam logic [WTAB_WORDS*8-1:0] WTAB_RESET =
    {8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
     8'h00, 8'h00, 8'h00, 8'h00, 8'h44, 8'h40, 8'h00};

  // Default-1 bits that are nonetheless ORed with their pins.
  localparam logic [WTAB_WORDS*8-1:0] WTAB_OR_ONES =
    {8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
     8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00};

  // Fixed upper bits of the 7-bit serial address.
  localparam logic [3:0] I2C_ADDR_HI = 4'h1;

  // Timing-reference preamble, the header remap thresholds and the clip levels.
  localparam logic [9:0] TRS_WORD0  = 10'h3FF;
  localparam logic [9:0] TRS_WORD12 = 10'h000;
  localparam logic [9:0] AUX_LOW    = 10'h3FC;
  localparam logic [9:0] AUX_TOP    = 10'h3FF;
  localparam logic [9:0] CLIP_LOW_IN  = 10'h003;
  localparam logic [9:0] CLIP_LOW_OUT = 10'h004;
  localparam logic [9:0] CLIP_HI_OUT  = 10'h3FB;

  typedef enum logic [2:0] {
    VHP_I2C_IDLE  = 3'b000,
    VHP_I2C_ADDR  = 3'b001,
    VHP_I2C_AACK  = 3'b010,
    VHP_I2C_WBYTE = 3'b011,
    VHP_I2C_WACK  = 3'b100,
    VHP_I2C_RBYTE = 3'b101,
    VHP_I2C_RACK  = 3'b110
  } vhp_i2c_state_e;

endpackage

// ---- hw/vhp_i2c_slave.sv ----
/*
  Serial slave for the host tables: start and stop detection, address match,
  byte receive with acknowledge and byte transmit.
  Assumes the serial pins arrive asynchronously and are far slower than clk;
  the table pointer lives in the parent, which answers rd_pulse at once.
*/
`timescale 1ns/1ps
module vhp_i2c_slave
  import vhp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       enable,
  input  wire logic       scl,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [2:0] addr_strap,
  input  wire logic [7:0] rd_byte,
  output logic            addr_pulse,
  output logic            wr_pulse,
  output logic            rd_pulse,
  output logic [7:0]      rx_byte
);
  import vhp_pkg::*;

  logic [1:0]     scl_s_q;
  logic [1:0]     sda_s_q;
  logic           scl_q;
  logic           sda_q;
  vhp_i2c_state_e state_q;
  logic [7:0]     shift_q;
  logic [3:0]     cnt_q;
  logic           first_q;
  logic           nack_q;
  logic           scl_rise;
  logic           scl_fall;
  logic           start_c;
  logic           stop_c;

  // Two-stage synchronisers; edges are judged by comparing the second stage with a third flop.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_s_q <= 2'b11;
      sda_s_q <= 2'b11;
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl};
      sda_s_q <= {sda_s_q[0], sda_in};
      scl_q   <= scl_s_q[1];
      sda_q   <= sda_s_q[1];
    end
  end

  assign scl_rise = scl_s_q[1] & ~scl_q;
  assign scl_fall = ~scl_s_q[1] & scl_q;
  assign start_c  = enable & scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
  assign stop_c   = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

  // Byte engine; bits are taken on the rising clock and driven after the fall.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= VHP_I2C_IDLE;
      shift_q    <= 8'h00;
      cnt_q      <= 4'h0;
      first_q    <= 1'b0;
      nack_q     <= 1'b0;
      sda_out    <= 1'b1;
      sda_oe     <= 1'b0;
      addr_pulse <= 1'b0;
      wr_pulse   <= 1'b0;
      rd_pulse   <= 1'b0;
      rx_byte    <= 8'h00;
    end else begin
      addr_pulse <= 1'b0;
      wr_pulse   <= 1'b0;
      rd_pulse   <= 1'b0;
      if (start_c) begin
        state_q <= VHP_I2C_ADDR;
        cnt_q   <= 4'h0;
        sda_oe  <= 1'b0;
      end else if (stop_c || !enable) begin
        state_q <= VHP_I2C_IDLE;
        sda_oe  <= 1'b0;
      end else if (scl_rise) begin
        unique case (state_q)
          VHP_I2C_ADDR, VHP_I2C_WBYTE: begin
            shift_q <= {shift_q[6:0], sda_q};
            cnt_q   <= cnt_q + 4'h1;
          end
          VHP_I2C_RACK: nack_q <= sda_q;
          default: cnt_q <= cnt_q;
        endcase
      end else if (scl_fall) begin
        unique case (state_q)
          VHP_I2C_IDLE: sda_oe <= 1'b0;
          VHP_I2C_ADDR: begin
            if (cnt_q == 4'h8) begin
              // Address is the fixed nibble followed by the straps.
              if (shift_q[7:1] == {I2C_ADDR_HI, addr_strap}) begin
                state_q <= VHP_I2C_AACK;
                sda_out <= 1'b0;
                sda_oe  <= 1'b1;
                first_q <= ~shift_q[0];
              end else begin
                state_q <= VHP_I2C_IDLE;
              end
            end
          end
          VHP_I2C_AACK, VHP_I2C_WACK: begin
            cnt_q <= 4'h0;
            if (shift_q[0] && state_q == VHP_I2C_AACK) begin
              // Read: fetch the byte at the pointer, which then advances.
              state_q  <= VHP_I2C_RBYTE;
              shift_q  <= {rd_byte[6:0], 1'b0};
              sda_out  <= rd_byte[7];
              sda_oe   <= 1'b1;
              rd_pulse <= 1'b1;
              cnt_q    <= 4'h1;
            end else begin
              state_q <= VHP_I2C_WBYTE;
              sda_oe  <= 1'b0;
            end
          end
          VHP_I2C_WBYTE: begin
            if (cnt_q == 4'h8) begin
              // First byte loads the pointer, later bytes are data.
              state_q    <= VHP_I2C_WACK;
              sda_out    <= 1'b0;
              sda_oe     <= 1'b1;
              rx_byte    <= shift_q;
              addr_pulse <= first_q;
              wr_pulse   <= ~first_q;
              first_q    <= 1'b0;
            end
          end
          VHP_I2C_RBYTE: begin
            if (cnt_q == 4'h8) begin
              state_q <= VHP_I2C_RACK;
              sda_oe  <= 1'b0;
            end else begin
              sda_out <= shift_q[7];
              shift_q <= {shift_q[6:0], 1'b0};
              cnt_q   <= cnt_q + 4'h1;
            end
          end
          VHP_I2C_RACK: begin
            if (nack_q) begin
              state_q <= VHP_I2C_IDLE;
            end else begin
              state_q  <= VHP_I2C_RBYTE;
              shift_q  <= {rd_byte[6:0], 1'b0};
              sda_out  <= rd_byte[7];
              sda_oe   <= 1'b1;
              rd_pulse <= 1'b1;
              cnt_q    <= 4'h1;
            end
          end
        endcase
      end
    end
  end

endmodule

// ---- hw/vhp_host_port.sv ----
/*
  Host configuration port and output stream fix-up. Holds the write table,
  serves both tables over the serial slave or the asynchronous parallel bus,
  merges table bits with their pins, and applies reference blanking, clipping,
  data blanking, reference insertion and auxiliary header remapping.
  Assumes an external flywheel supplies position strobes and the reference ID
  word, and the read table image is supplied by the error-detection core.
*/
`timescale 1ns/1ps
module vhp_host_port
  import vhp_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      host_port_select,
  input  wire logic                      scl,
  input  wire logic                      sda_in,
  output logic                           sda_out,
  output logic                           sda_oe,
  input  wire logic [2:0]                addr_strap,
  input  wire logic                      cs_n,
  input  wire logic                      rd_wr,
  input  wire logic                      addr_data,
  input  wire logic [7:0]                p_in,
  output logic [7:0]                     p_out,
  output logic                           p_oe,
  input  wire logic [vhp_pkg::WTAB_WORDS*8-1:0] wtab_pins,
  input  wire logic                      combined_clip_fixup_pin,
  output logic [vhp_pkg::WTAB_WORDS*8-1:0] wtab_eff,
  input  wire logic [vhp_pkg::RTAB_WORDS*8-1:0] rtab_image,
  input  wire logic [9:0]                vid_in,
  input  wire logic                      std_detected,
  input  wire logic                      flywheel_sync,
  input  wire logic                      input_lost,
  input  wire logic [3:0]                fw_trs_slot,
  input  wire logic [9:0]                fw_trs_id,
  input  wire logic                      ref_misplaced,
  input  wire logic                      active_picture,
  input  wire logic                      aux_header_word,
  input  wire logic [9:0]                blank_level,
  output logic [9:0]                     vid_out,
  output logic                           ins_armed
);
  import vhp_pkg::*;

  logic [7:0]            wtab_q [1:WTAB_WORDS];
  logic [WTAB_WORDS*8-1:0] wtab_flat;
  logic [TAB_ADDR_W-1:0] ptr_q;
  logic [1:0]            sel_s_q;
  logic [1:0]            cs_s_q;
  logic [1:0]            rw_s_q;
  logic [1:0]            ad_s_q;
  logic [7:0]            p_s0_q;
  logic [7:0]            p_s1_q;
  logic                  cs_q;
  logic                  par_mode;
  logic                  cs_fall;
  logic                  par_addr_wr;
  logic                  par_data_wr;
  logic                  par_data_rd;
  logic                  i2c_addr;
  logic                  i2c_wr;
  logic                  i2c_rd;
  logic [7:0]            i2c_rx;
  logic [7:0]            rd_byte;
  logic                  ld_addr;
  logic                  do_wr;
  logic [7:0]            wr_byte;
  logic                  adv;
  logic                  ins_ok_q;
  logic                  clip_en;
  logic                  blank_en;
  logic                  remap_en;
  logic                  insert_en;
  logic                  ref_blank_en;
  logic [9:0]            w_refblank;
  logic [9:0]            w_clip;
  logic [9:0]            w_blank;
  logic [9:0]            w_ins;
  logic [9:0]            w_aux;

  // Host port pins are synchronised before use, except by the bus enable.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sel_s_q <= 2'b00;
      cs_s_q  <= 2'b11;
      rw_s_q  <= 2'b11;
      ad_s_q  <= 2'b00;
      p_s0_q  <= 8'h00;
      p_s1_q  <= 8'h00;
      cs_q    <= 1'b1;
    end else begin
      sel_s_q <= {sel_s_q[0], host_port_select};
      cs_s_q  <= {cs_s_q[0], cs_n};
      rw_s_q  <= {rw_s_q[0], rd_wr};
      ad_s_q  <= {ad_s_q[0], addr_data};
      p_s0_q  <= p_in;
      p_s1_q  <= p_s0_q;
      cs_q    <= cs_s_q[1];
    end
  end

  // Mode pin picks the access path; the other path is ignored.
  assign par_mode = ~sel_s_q[1];

  // Transfers are taken at the falling edge of chip select.
  assign cs_fall     = par_mode & cs_q & ~cs_s_q[1];
  assign par_addr_wr = cs_fall & ~rw_s_q[1] & ad_s_q[1];
  assign par_data_wr = cs_fall & ~rw_s_q[1] & ~ad_s_q[1];
  assign par_data_rd = cs_fall & rw_s_q[1];

  vhp_i2c_slave u_i2c (
    .clk        (clk),
    .nrst       (nrst),
    .enable     (sel_s_q[1]),
    .scl        (scl),
    .sda_in     (sda_in),
    .sda_out    (sda_out),
    .sda_oe     (sda_oe),
    .addr_strap (addr_strap),
    .rd_byte    (rd_byte),
    .addr_pulse (i2c_addr),
    .wr_pulse   (i2c_wr),
    .rd_pulse   (i2c_rd),
    .rx_byte    (i2c_rx)
  );

  // Both paths share one pointer and one write port.
  assign ld_addr = par_addr_wr | i2c_addr;
  assign do_wr   = par_data_wr | i2c_wr;
  assign wr_byte = par_mode ? p_s1_q : i2c_rx;
  assign adv     = do_wr | par_data_rd | i2c_rd;

  // Read table lookup; locations outside 1 to 23 read as zero.
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q >= TAB_FIRST && ptr_q <= TAB_ADDR_W'(RTAB_WORDS)) begin
      rd_byte = rtab_image[(ptr_q - TAB_FIRST) * 8 +: 8];
    end
  end

  // Pointer loads on an address phase and steps after each data byte.
  // The pointer keeps its value across a halted read, so a later read
  // resumes at the following location.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ptr_q <= TAB_FIRST;
    end else if (ld_addr) begin
      ptr_q <= wr_byte[TAB_ADDR_W-1:0];
    end else if (adv) begin
      ptr_q <= ptr_q + TAB_ADDR_W'(1);
    end
  end

  // Write table storage; writes outside 1 to 15 are dropped.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 1; i <= WTAB_WORDS; i++) begin
        wtab_q[i] <= WTAB_RESET[(i-1)*8 +: 8];
      end
    end else if (do_wr && ptr_q >= TAB_FIRST && ptr_q <= TAB_ADDR_W'(WTAB_WORDS)) begin
      wtab_q[ptr_q] <= wr_byte;
    end
  end

  // Parallel read data is held in a flop and refreshed per read strobe.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      p_out <= 8'h00;
    end else if (par_data_rd) begin
      p_out <= rd_byte;
    end
  end

  // Bus enable follows the raw pins with no clock, so release is immediate.
  assign p_oe = rd_wr & ~cs_n;

  // Merge each table bit with its pin by its reset value: 0 ORs, 1 ANDs, except the checksum bit, which ORs.
  genvar gb;
  generate
    for (gb = 0; gb < WTAB_WORDS*8; gb++) begin : g_merge
      assign wtab_flat[gb] = wtab_q[gb/8 + 1][gb%8];
      if (WTAB_RESET[gb] && !WTAB_OR_ONES[gb]) begin : g_and
        assign wtab_eff[gb] = wtab_flat[gb] & wtab_pins[gb];
      end else if ((gb / 8) == (PROC_ADDR - 1) && ((gb % 8) == BIT_CLIP ||
                   (gb % 8) == BIT_INSERT || (gb % 8) == BIT_REF_BLANK)) begin : g_clip
        assign wtab_eff[gb] = wtab_flat[gb] | wtab_pins[gb] | combined_clip_fixup_pin;
      end else begin : g_or
        assign wtab_eff[gb] = wtab_flat[gb] | wtab_pins[gb];
      end
    end
  endgenerate

  // Control fields of the processing byte, after pin merging.
  assign clip_en      = wtab_eff[(PROC_ADDR - 1) * 8 + BIT_CLIP];
  assign blank_en     = wtab_eff[(PROC_ADDR - 1) * 8 + BIT_BLANK_EN];
  assign remap_en     = wtab_eff[(PROC_ADDR - 1) * 8 + BIT_AUX_REMAP];
  assign insert_en    = wtab_eff[(PROC_ADDR - 1) * 8 + BIT_INSERT];
  assign ref_blank_en = wtab_eff[(PROC_ADDR - 1) * 8 + BIT_REF_BLANK];

  // Insertion arms once the standard is known and the flywheel locked,
  // and stays armed through loss of input on the last standard.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ins_ok_q <= 1'b0;
    end else if (std_detected && flywheel_sync) begin
      ins_ok_q <= 1'b1;
    end else if (!input_lost && !std_detected) begin
      ins_ok_q <= 1'b0;
    end
  end
  assign ins_armed = ins_ok_q;

  // Processing order: reference blanking, clip, data blanking, insertion.
  always_comb begin
    w_refblank = (ref_blank_en && ref_misplaced) ? blank_level : vid_in;
    w_clip     = w_refblank;
    if (clip_en && active_picture) begin
      if (w_refblank <= CLIP_LOW_IN) begin
        w_clip = CLIP_LOW_OUT;
      end else if (w_refblank >= AUX_LOW) begin
        w_clip = CLIP_HI_OUT;
      end
    end
    w_blank = blank_en ? w_clip : blank_level;
    w_ins   = w_blank;
    // Reference words replace the stream even where one already stands,
    // which also repairs a bad ID word.
    if (insert_en && ins_ok_q) begin
      unique case (1'b1)
        fw_trs_slot[0]: w_ins = TRS_WORD0;
        fw_trs_slot[1]: w_ins = TRS_WORD12;
        fw_trs_slot[2]: w_ins = TRS_WORD12;
        fw_trs_slot[3]: w_ins = fw_trs_id;
        default:        w_ins = w_blank;
      endcase
    end
    // Header words from 3FC up are promoted for 8-bit sources.
    w_aux = (remap_en && aux_header_word && w_ins >= AUX_LOW) ? AUX_TOP : w_ins;
  end

  // One register stage on the video output.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vid_out <= 10'h000;
    end else begin
      vid_out <= w_aux;
    end
  end

endmodule

// ---- bench/vhp_host_port_props.sv ----
/* Concurrent checks on the host port pins and the output stream.
   Bound to vhp_host_port from the bench; sees its ports only. */
`timescale 1ns/1ps
module vhp_host_port_props (
  input wire logic                               clk,
  input wire logic                               nrst,
  input wire logic                               host_port_select,
  input wire logic                               cs_n,
  input wire logic                               rd_wr,
  input wire logic                               p_oe,
  input wire logic [7:0]                         p_out,
  input wire logic [vhp_pkg::WTAB_WORDS*8-1:0]   wtab_pins,
  input wire logic                               combined_clip_fixup_pin,
  input wire logic [vhp_pkg::WTAB_WORDS*8-1:0]   wtab_eff,
  input wire logic [9:0]                         vid_in,
  input wire logic                               std_detected,
  input wire logic                               input_lost,
  input wire logic [3:0]                         fw_trs_slot,
  input wire logic [9:0]                         fw_trs_id,
  input wire logic                               ref_misplaced,
  input wire logic                               active_picture,
  input wire logic                               aux_header_word,
  input wire logic [9:0]                         vid_out,
  input wire logic                               ins_armed
);
  import vhp_pkg::*;
  localparam int PB = 8 * (int'(PROC_ADDR) - 1);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Serial mode held long enough that a late parallel strobe has drained the synchroniser.
  sequence s_serial_mode;
    host_port_select [*8];
  endsequence
  // A reserved header word that no earlier stage of the chain touches.
  sequence s_aux_reserved;
    aux_header_word && wtab_eff[PB+BIT_AUX_REMAP] && wtab_eff[PB+BIT_BLANK_EN] && vid_in >= AUX_LOW
      && fw_trs_slot == 4'h0 && !ref_misplaced && !active_picture;
  endsequence

  property p_bus_drive;
    p_oe == (rd_wr && !cs_n);
  endproperty
  property p_serial_quiet;
    s_serial_mode |-> $stable(p_out);
  endproperty
  property p_combined_or;
    combined_clip_fixup_pin |-> wtab_eff[PB+BIT_CLIP] && wtab_eff[PB+BIT_INSERT] && wtab_eff[PB+BIT_REF_BLANK];
  endproperty
  property p_blank_and;
    !wtab_pins[PB+BIT_BLANK_EN] |-> !wtab_eff[PB+BIT_BLANK_EN];
  endproperty
  property p_remap;
    s_aux_reserved |=> vid_out == AUX_TOP;
  endproperty
  property p_ins_first;
    ins_armed && wtab_eff[PB+BIT_INSERT] && fw_trs_slot == 4'b0001 |=> vid_out == TRS_WORD0;
  endproperty
  property p_ins_id;
    ins_armed && wtab_eff[PB+BIT_INSERT] && fw_trs_slot == 4'b1000 && !aux_header_word
      |=> vid_out == $past(fw_trs_id);
  endproperty
  property p_disarm;
    !std_detected && !input_lost |=> !ins_armed;
  endproperty

  a_bus_drive: assert property (p_bus_drive) else $error("bus enable wrong");
  a_serial_quiet: assert property (p_serial_quiet) else $error("read data moved in serial mode");
  a_combined_or: assert property (p_combined_or) else $error("combined pin not ORed");
  a_blank_and: assert property (p_blank_and) else $error("blank enable not ANDed");
  a_remap: assert property (p_remap) else $error("header word not remapped");
  a_ins_first: assert property (p_ins_first) else $error("first reference word wrong");
  a_ins_id: assert property (p_ins_id) else $error("reference id not overwritten");
  a_disarm: assert property (p_disarm) else $error("inserter armed without standard");
endmodule

// ---- bench/vhp_host_model.sv ----
/* Host controller model: strobes the parallel bus and drives the serial port.
   Assumes the bench resolves the open-drain data line with a pull-up. */
`timescale 1ns/1ps
module vhp_host_model (
  input  wire logic       clk,
  input  wire logic [7:0] p_out,
  input  wire logic       p_oe,
  input  wire logic       sda,
  output logic            cs_n,
  output logic            rd_wr,
  output logic            addr_data,
  output logic [7:0]      p_in,
  output logic            scl,
  output logic            sda_host
);
  localparam int HALF = 25;
  logic [7:0] p_drv;

  // The device's byte wins while it drives; a released bus shows the inverse of our last byte.
  assign p_in = p_oe ? p_out : p_drv;

  // Idle levels of an unused host port.
  initial begin
    cs_n = 1'b1;
    rd_wr = 1'b1;
    addr_data = 1'b0;
    p_drv = 8'h00;
    scl = 1'b1;
    sda_host = 1'b1;
  end

  // One strobe: lines settle before chip select falls and hold well past the synchroniser.
  task automatic par_cycle(input logic rw, input logic ad, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    rd_wr <= rw;
    addr_data <= ad;
    p_drv <= d;
    repeat (3) @(posedge clk);
    cs_n <= 1'b0;
    repeat (6) @(posedge clk);
    q = p_out;
    cs_n <= 1'b1;
    p_drv <= ~d;
    repeat (4) @(posedge clk);
  endtask

  // One serial bit; data moves a few cycles after the clock falls so no false start is seen.
  task automatic i2c_bit(input logic b, output logic s);
    sda_host <= b;
    repeat (HALF) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF) @(posedge clk);
    s = sda;
    scl <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  // Start, address with write, table pointer, one data byte, stop; ack is high if all were taken.
  task automatic i2c_write(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d, output logic ack);
    logic [26:0] bits;
    logic s;
    bits = {dev, 1'b0, 1'b1, ptr, 1'b1, d, 1'b1};
    ack = 1'b1;
    @(posedge clk);
    cs_n <= 1'b1;
    rd_wr <= 1'b1;
    addr_data <= 1'b0;
    p_drv <= 8'h00;
    sda_host <= 1'b0;
    repeat (HALF) @(posedge clk);
    scl <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 26; i >= 0; i--) begin
      i2c_bit(bits[i], s);
      if (i % 9 == 0) ack &= ~s;
    end
    sda_host <= 1'b0;
    repeat (HALF) @(posedge clk);
    scl <= 1'b1;
    repeat (HALF) @(posedge clk);
    sda_host <= 1'b1;
    repeat (HALF) @(posedge clk);
  endtask
endmodule

// ---- bench/vhp_tb.sv ----
/* Self-checking bench for vhp_host_port: table access over both host ports,
   pin merging, header remapping and reference insertion. Assumes the host model beside it. */
`timescale 1ns/1ps
module tb;
  import vhp_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, host_port_select = 1'b0, combined_clip_fixup_pin = 1'b0;
  logic std_detected = 1'b0, flywheel_sync = 1'b0, input_lost = 1'b0, ref_misplaced = 1'b0;
  logic active_picture = 1'b0, aux_header_word = 1'b0, ack;
  logic [2:0] addr_strap = 3'b101;
  logic [3:0] fw_trs_slot = 4'h0;
  logic [9:0] vid_in = 10'h000, fw_trs_id = 10'h2D8, blank_level = 10'h040, vid_out;
  logic [WTAB_WORDS*8-1:0] wtab_pins = '0, wtab_eff;
  logic [RTAB_WORDS*8-1:0] rtab_image;
  logic cs_n, rd_wr, addr_data, p_oe, scl, sda_host, sda_out, sda_oe, ins_armed;
  logic [7:0] p_in, p_out, q;
  logic [9:0] trs_in [4] = '{10'h3FF, 10'h000, 10'h000, 10'h2C7};
  logic [9:0] trs_exp [4] = '{10'h3FF, 10'h000, 10'h000, 10'h2D8};
  int n_mismatch = 0, check_count = 0, cycles = 0;
  wire sda_line = sda_host & ~(sda_oe & ~sda_out);

  vhp_host_port i_dut (.clk, .nrst, .host_port_select, .scl, .sda_in(sda_line), .sda_out, .sda_oe,
    .addr_strap, .cs_n, .rd_wr, .addr_data, .p_in, .p_out, .p_oe, .wtab_pins, .combined_clip_fixup_pin,
    .wtab_eff, .rtab_image, .vid_in, .std_detected, .flywheel_sync, .input_lost, .fw_trs_slot, .fw_trs_id,
    .ref_misplaced, .active_picture, .aux_header_word, .blank_level, .vid_out, .ins_armed);
  vhp_host_model i_host (.clk, .p_out, .p_oe, .sda(sda_line), .cs_n, .rd_wr, .addr_data, .p_in, .scl, .sda_host);

  // Clock and a cycle ceiling well above the run's few thousand cycles.
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // One video word in, its processed form compared a cycle later.
  task automatic vid(input logic [9:0] v, input logic [3:0] s, input logic [9:0] e);
    @(posedge clk);
    vid_in <= v;
    fw_trs_slot <= s;
    @(posedge clk);
    #1 chk("vid_out", e, vid_out);
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence: pin merge, parallel port, serial port, then reference insertion.
  initial begin
    for (int n = 1; n <= 23; n++) rtab_image[8*(n-1) +: 8] = 8'(8'hA0 + n);
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk("loc2 vblank", 1'b0, wtab_eff[14]);
    chk("loc3", 8'h04, wtab_eff[23:16]);
    @(posedge clk);
    wtab_pins[14] <= 1'b1;
    wtab_pins[22] <= 1'b1;
    combined_clip_fixup_pin <= 1'b1;
    @(posedge clk);
    #1 chk("loc2 vblank", 1'b1, wtab_eff[14]);
    chk("loc3", 8'hC7, wtab_eff[23:16]);
    combined_clip_fixup_pin <= 1'b0;
    i_host.par_cycle(1'b0, 1'b1, 8'h03, q);
    i_host.par_cycle(1'b0, 1'b0, 8'h60, q);
    i_host.par_cycle(1'b0, 1'b0, 8'h81, q);
    chk("loc3", 8'h60, wtab_eff[23:16]);
    chk("loc4", 8'h81, wtab_eff[31:24]);
    wtab_pins[18] <= 1'b1;
    aux_header_word <= 1'b1;
    for (int k = 0; k < 4; k++) vid(10'(10'h3FC + k), 4'h0, 10'h3FF);
    chk("loc3 chksm", 1'b1, wtab_eff[18]);
    aux_header_word <= 1'b0;
    vid(10'h3FC, 4'h0, 10'h3FC);
    i_host.par_cycle(1'b0, 1'b1, 8'h05, q);
    i_host.par_cycle(1'b1, 1'b0, 8'h00, q);
    chk("read", 8'hA5, q);
    i_host.par_cycle(1'b1, 1'b0, 8'h00, q);
    chk("read", 8'hA6, q);
    i_host.par_cycle(1'b0, 1'b1, 8'h17, q);
    i_host.par_cycle(1'b1, 1'b0, 8'h00, q);
    chk("read", 8'hB7, q);
    i_host.par_cycle(1'b1, 1'b0, 8'h00, q);
    chk("read", 8'h00, q);
    host_port_select <= 1'b1;
    i_host.par_cycle(1'b0, 1'b1, 8'h03, q);
    i_host.par_cycle(1'b0, 1'b0, 8'h00, q);
    chk("loc3", 8'h64, wtab_eff[23:16]);
    i_host.i2c_write({4'b0001, 3'b101}, 8'h01, 8'h5A, ack);
    chk("ack", 1'b1, ack);
    chk("loc1", 8'h5A, wtab_eff[7:0]);
    i_host.i2c_write({4'b0001, 3'b100}, 8'h01, 8'h33, ack);
    chk("ack", 1'b0, ack);
    chk("loc1", 8'h5A, wtab_eff[7:0]);
    combined_clip_fixup_pin <= 1'b1;
    std_detected <= 1'b1;
    flywheel_sync <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk("armed", 1'b1, ins_armed);
    // Second pass runs with the input gone, on the standard seen last.
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 4; k++) vid(trs_in[k], 4'(4'b0001 << k), trs_exp[k]);
      input_lost <= 1'b1;
      std_detected <= 1'b0;
      repeat (3) @(posedge clk);
      #1 chk("armed", 1'b1, ins_armed);
    end
    input_lost <= 1'b0;
    fw_trs_slot <= 4'h0;
    repeat (3) @(posedge clk);
    #1 chk("armed", 1'b0, ins_armed);
    print_verdict();
  end
endmodule

bind vhp_host_port vhp_host_port_props i_props (.clk, .nrst, .host_port_select, .cs_n, .rd_wr, .p_oe, .p_out,
  .wtab_pins, .combined_clip_fixup_pin, .wtab_eff, .vid_in, .std_detected, .input_lost, .fw_trs_slot,
  .fw_trs_id, .ref_misplaced, .active_picture, .aux_header_word, .vid_out, .ins_armed);
